// ---- rtl/fslc_checker.sv ----
// flash security lock checker: judges code reads, mailbox commands and host commands
//
// Notes on behaviour
// - a code read from an unlocked or soft-locked region never returns bytes of a hard-locked block.
// - hard lock may cover both blocks or only the secondary 8 KByte block.
// - every host or mailbox command aimed at a hard-locked block is ignored, except whole-chip erase, verify at level two and any command at level one.
// - mailbox block erase, sector erase, program and verify run on a soft-locked block when issued from a locked block.
// - in host programming mode a soft-locked block is treated as hard-locked.
// - the lock state shows in bits 7 to 5 of the flash status register.
// - exactly four security levels govern the lock of the primary and secondary blocks.
// - with no lock bit programmed both blocks are fully open.
// - level two forbids programming both blocks but allows reading by byte verify.
// - level three offers secondary hard with primary soft, both soft, or both hard.
// - level three with both locked is level two without byte verify reads.
// - level four refuses all reads and programming and refuses boot from external memory.
// - mailbox chip erase runs only when executing externally and not at level four.
// - mailbox commands are taken only while config bit 6 is set.
//
// register map, 8-bit data, read data in the cycle after the strobe
//   0: status, lock bits in [7:5], rest zero
//   1: config, bit 6 enables mailbox commands
//   2: lock bits [2:0], writes only set bits
//   3: mailbox, code in [2:0], a write starts a judgement
//   4: target, bit 0 picks the block
//   5: result, bit 0 accepted, bit 1 refused
//   6, 7: unused, read zero
//   8 to 15: decode table, write only, read zero
// status and result ignore writes, so no lock state can be faked
//
// table entry, one per lock-bit pattern
//   [7:4] level one-hot: 1 open, 2 verify only, 4 per block, 8 sealed
//   [3:2] secondary lock: 0 open, 1 guarded update, 2 hard
//   [1:0] primary lock, same coding
//   a level that is not one-hot is sealed: a bad entry fails safe
//   lock code 3 is not valid and must not be written
//
// default table after reset
//   0: open, both blocks open
//   1: verify level, both hard
//   2: per block, secondary hard, primary guarded
//   3: per block, both guarded
//   4: per block, both hard
//   5 to 7: sealed
// reset restores this map; table writes do not survive it
//
// timing
//   writes land at the strobe edge; the master never waits
//   the table read trails the lock bits by one edge,
//   so requests wait two edges after a lock write or reset
//   a code read gets valid or denied one cycle later
//   a command gets go or denied one cycle later
//   the boot block output trails the table by one more cycle
//   pulses stand one cycle; op and block hold their last value
//
// arbitration
//   mailbox write and host command together: the mailbox wins,
//   and the dropped host command leaves the lock bits alone
//   chip erase and lock write together: the erase wins
//
// requester origin
//   the core reports external execution and its source block
//   a code read from a hard-locked block may read hard-locked bytes
//   a mailbox command is from a locked block when the core runs
//   internally from a soft or hard locked block
//   the pin is synchronised, so a change takes two edges
//   to reach the chip erase check; reset means internal execution
//
// host port
//   a host request counts only while host mode is high
//   host mode is a level and is not latched per request
//   in host mode a guarded update lock counts as hard
//   host chip erase is taken at every level, clears lock bits
//
// outputs, all from flip-flops
//   o_reg_rdata       zero outside the cycle after a read
//   o_rd_valid        read passed, o_rd_data holds the byte
//   o_rd_denied       read refused, o_rd_data is zero
//   o_fl_go           command handed to the flash engine
//   o_fl_op, o_fl_blk op and block of the last command
//   o_fl_verify_open  accepted verify, byte may go back
//   o_cmd_denied      command refused, engine not started
//   o_ext_boot_block  sealed, no boot from external memory
//   a missed pulse is not repeated
//
// core inputs share this clock; only the pin is synchronised
//
// op codes: 1 block erase, 2 sector erase, 3 program,
// 4 verify, 5 chip erase; 0, 6 and 7 are not mailbox commands
//
// hazards
//   a request inside the table lag sees the old level,
//   which is why software waits after a lock write
//   table writes change verdicts two edges later, as lock writes do
//   the table is writable at every level; trusted code must own it
//
// limitations
//   no flash timing; the engine gets a go and reports nothing
//   no busy check: back-to-back commands are judged alike
//   a refused read returns zero; watch the denied pulse
//   no interrupt; software polls the result register
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "fslc_defines.svh"
module fslc_checker (
   input  wire logic                     i_sys_clk,
   input  wire logic                     i_rstn,
   // register port
   input  wire logic [`FSLC_ADDR_W-1:0]  i_reg_addr,
   input  wire logic [7:0]               i_reg_wdata,
   input  wire logic                     i_reg_wr,
   input  wire logic                     i_reg_rd,
   output logic [7:0]                    o_reg_rdata,
   // code read request from the core
   input  wire logic                     i_rd_req,
   input  wire logic                     i_rd_blk,
   input  wire logic                     i_rd_src_ext,
   input  wire logic                     i_rd_src_blk,
   input  wire logic [7:0]               i_rd_flash_data,
   output logic                          o_rd_valid,
   output logic [7:0]                    o_rd_data,
   output logic                          o_rd_denied,
   // host programmer command
   input  wire logic                     i_host_mode,
   input  wire logic                     i_host_req,
   input  wire fslc_pkg::fslc_op_t       i_host_op,
   input  wire logic                     i_host_blk,
   // pin: low selects external program memory
   input  wire logic                     i_ext_access_n,
   // command out to the flash engine
   output logic                          o_fl_go,
   output fslc_pkg::fslc_op_t            o_fl_op,
   output logic                          o_fl_blk,
   output logic                          o_fl_verify_open,
   output logic                          o_cmd_denied,
   output logic                          o_ext_boot_block
);
   import fslc_pkg::*;

   fslc_table_if tbl ();
   fslc_table_mem u_tbl (
      .i_sys_clk (i_sys_clk),
      .i_rstn    (i_rstn),
      .tbl       (tbl)
   );

   // software-visible registers
   logic [7:0]  config_reg;
   logic [2:0]  lockbits_reg;
   logic [7:0]  mailbox_reg;
   logic [7:0]  target_reg;
   logic [7:0]  result_reg;

   // pin synchroniser
   logic [1:0]  ext_sync_reg;

   // answer flops behind the outputs
   logic [7:0]  rdata_reg;
   logic        rd_valid_reg;
   logic [7:0]  rd_data_reg;
   logic        rd_denied_reg;

   // command flops towards the flash engine
   logic        fl_go_reg;
   fslc_op_t    fl_op_reg;
   logic        fl_blk_reg;
   logic        verify_open_reg;
   logic        cmd_denied_reg;
   logic        ext_boot_block_reg;

   // external access pin passes two flops before use
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         ext_sync_reg <= 2'h3;
      end else begin
         ext_sync_reg <= {ext_sync_reg[0], i_ext_access_n};
      end
   end
   wire ext_exec = ~ext_sync_reg[1];

   // table lookup keyed by the lock bits; one cycle of latency after a change
   assign tbl.rd_idx  = lockbits_reg;
   assign tbl.wr_en   = i_reg_wr && i_reg_addr[3];
   assign tbl.wr_idx  = i_reg_addr[2:0];
   assign tbl.wr_data = fslc_entry_t'(i_reg_wdata);
   wire fslc_entry_t cur = tbl.rd_data;

   // level decode; an unknown level code falls back to sealed
   wire lvl4 = (cur.level == FSLC_LVL4) || !(cur.level inside {FSLC_LVL1, FSLC_LVL2, FSLC_LVL3});
   wire lvl2 = (cur.level == FSLC_LVL2) && !lvl4;
   wire lvl1 = (cur.level == FSLC_LVL1) && !lvl4;

   // effective lock of a block for a requester
   function automatic fslc_lock_t fslc_blk_lock(input fslc_entry_t e, input logic blk);
      return blk ? e.blk1 : e.blk0;
   endfunction

   function automatic logic fslc_hard_for(input fslc_entry_t e, input logic blk, input logic host);
      fslc_lock_t l;
      l = fslc_blk_lock(e, blk);
      return (l == FSLC_HARD) || (host && l == FSLC_SOFT);
   endfunction

   // code read judgement
   wire rd_tgt_hard  = fslc_blk_lock(cur, i_rd_blk) == FSLC_HARD;
   wire rd_src_lockd = !i_rd_src_ext && fslc_blk_lock(cur, i_rd_src_blk) == FSLC_HARD;
   wire rd_allow     = !lvl4 && (!rd_tgt_hard || rd_src_lockd);

   // mailbox command judgement
   wire       mb_wr    = i_reg_wr && i_reg_addr == `FSLC_OFS_MAILBOX;
   wire       mb_en    = config_reg[`FSLC_CFG_MB_EN_BIT];
   wire [2:0] mb_code  = i_reg_wdata[2:0];
   wire       mb_blk   = target_reg[`FSLC_BLK1_BIT];
   wire       mb_src_x = !i_rd_src_ext;
   wire fslc_lock_t mb_tl = fslc_blk_lock(cur, mb_blk);
   wire fslc_lock_t mb_sl = fslc_blk_lock(cur, i_rd_src_blk);
   wire       mb_known = mb_code inside {FSLC_OP_BERASE, FSLC_OP_SERASE, FSLC_OP_PROG, FSLC_OP_VERIFY,
                                         FSLC_OP_CERASE};
   wire       mb_srclk = mb_src_x && mb_sl != FSLC_UNLOCKED;
   wire       mb_soft  = mb_tl == FSLC_SOFT && mb_srclk;
   wire       mb_blkok = lvl1 || (mb_tl == FSLC_UNLOCKED) || mb_soft
                         || (lvl2 && mb_code == FSLC_OP_VERIFY);
   wire       mb_cerok = ext_exec && !lvl4;
   wire       mb_ok    = mb_en && mb_known && !lvl4 &&
                         ((mb_code == FSLC_OP_CERASE) ? mb_cerok : mb_blkok);

   // host command judgement; chip erase passes at every level
   wire host_go   = i_host_req && i_host_mode;
   wire host_hard = fslc_hard_for(cur, i_host_blk, 1'b1);
   wire host_ok   = (i_host_op == FSLC_OP_CERASE) ||
                    (!lvl4 && (!host_hard || lvl1 || (lvl2 && i_host_op == FSLC_OP_VERIFY)));

   // read data mux
   wire [7:0] stat_val = {lockbits_reg, 5'h00};
   wire [7:0] rd_mux =
      (i_reg_addr == `FSLC_OFS_STATUS)   ? stat_val :
      (i_reg_addr == `FSLC_OFS_CONFIG)   ? config_reg :
      (i_reg_addr == `FSLC_OFS_LOCKBITS) ? {5'h00, lockbits_reg} :
      (i_reg_addr == `FSLC_OFS_MAILBOX)  ? mailbox_reg :
      (i_reg_addr == `FSLC_OFS_TARGET)   ? target_reg :
      (i_reg_addr == `FSLC_OFS_RESULT)   ? result_reg :
      (i_reg_addr[3])                    ? 8'h00 : 8'h00;

   // software registers; lock bits only ever get more set, chip erase clears them
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         config_reg   <= `FSLC_RST_CONFIG;
         lockbits_reg <= `FSLC_RST_LOCKBITS;
         target_reg   <= 8'h00;
      end else begin
         if (i_reg_wr && i_reg_addr == `FSLC_OFS_CONFIG) config_reg <= i_reg_wdata;
         if (i_reg_wr && i_reg_addr == `FSLC_OFS_TARGET) target_reg <= i_reg_wdata;
         if ((host_go && !mb_wr && host_ok && i_host_op == FSLC_OP_CERASE) ||
             (mb_wr && mb_ok && mb_code == FSLC_OP_CERASE)) begin
            lockbits_reg <= `FSLC_RST_LOCKBITS;
         end else if (i_reg_wr && i_reg_addr == `FSLC_OFS_LOCKBITS) begin
            lockbits_reg <= lockbits_reg | i_reg_wdata[2:0];
         end
      end
   end

   // mailbox and result registers; result bit0 accepted, bit1 refused
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         mailbox_reg <= `FSLC_RST_MAILBOX;
         result_reg  <= 8'h00;
      end else if (mb_wr) begin
         mailbox_reg <= i_reg_wdata;
         result_reg  <= {6'h00, !mb_ok, mb_ok};
      end
   end

   // register read data one cycle after the strobe
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= i_reg_rd ? rd_mux : 8'h00;
      end
   end

   // code read answer, zero data when refused
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         rd_valid_reg  <= 1'b0;
         rd_data_reg   <= 8'h00;
         rd_denied_reg <= 1'b0;
      end else begin
         rd_valid_reg  <= i_rd_req && rd_allow;
         rd_data_reg   <= (i_rd_req && rd_allow) ? i_rd_flash_data : 8'h00;
         rd_denied_reg <= i_rd_req && !rd_allow;
      end
   end

   // flash engine command: mailbox takes priority over host in the same cycle
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         fl_go_reg       <= 1'b0;
         fl_op_reg       <= FSLC_OP_READ;
         fl_blk_reg      <= 1'b0;
         verify_open_reg <= 1'b0;
         cmd_denied_reg  <= 1'b0;
      end else if (mb_wr) begin
         fl_go_reg       <= mb_ok;
         fl_op_reg       <= fslc_op_t'(mb_code);
         fl_blk_reg      <= mb_blk;
         verify_open_reg <= mb_ok && mb_code == FSLC_OP_VERIFY;
         cmd_denied_reg  <= !mb_ok;
      end else if (host_go) begin
         fl_go_reg       <= host_ok;
         fl_op_reg       <= i_host_op;
         fl_blk_reg      <= i_host_blk;
         verify_open_reg <= host_ok && i_host_op == FSLC_OP_VERIFY;
         cmd_denied_reg  <= !host_ok;
      end else begin
         fl_go_reg       <= 1'b0;
         verify_open_reg <= 1'b0;
         cmd_denied_reg  <= 1'b0;
      end
   end

   // boot from external memory is blocked at the sealed level
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         ext_boot_block_reg <= 1'b0;
      end else begin
         ext_boot_block_reg <= lvl4;
      end
   end

   assign o_reg_rdata      = rdata_reg;
   assign o_rd_valid       = rd_valid_reg;
   assign o_rd_data        = rd_data_reg;
   assign o_rd_denied      = rd_denied_reg;
   assign o_fl_go          = fl_go_reg;
   assign o_fl_op          = fl_op_reg;
   assign o_fl_blk         = fl_blk_reg;
   assign o_fl_verify_open = verify_open_reg;
   assign o_cmd_denied     = cmd_denied_reg;
   assign o_ext_boot_block = ext_boot_block_reg;
endmodule

// ---- rtl/fslc_defines.svh ----
// register offsets, field positions and reset values for the flash lock checker
`ifndef FSLC_DEFINES_SVH
`define FSLC_DEFINES_SVH
`define FSLC_ADDR_W          4
`define FSLC_OFS_STATUS      4'h0
`define FSLC_OFS_CONFIG      4'h1
`define FSLC_OFS_LOCKBITS    4'h2
`define FSLC_OFS_MAILBOX     4'h3
`define FSLC_OFS_TARGET      4'h4
`define FSLC_OFS_RESULT      4'h5
`define FSLC_OFS_DECODE      4'h8
`define FSLC_STAT_LOCK_HI    7
`define FSLC_STAT_LOCK_LO    5
`define FSLC_CFG_MB_EN_BIT   6
`define FSLC_RST_CONFIG      8'h00
`define FSLC_RST_LOCKBITS    3'h0
`define FSLC_RST_MAILBOX     8'h00
`define FSLC_BLK1_BIT        0
`endif

// ---- rtl/fslc_pkg.sv ----
// types shared by the flash lock checker and its decode table
package fslc_pkg;
   // lock of one block
   typedef enum logic [1:0] {
      FSLC_UNLOCKED = 2'h0,
      FSLC_SOFT     = 2'h1,
      FSLC_HARD     = 2'h2
   } fslc_lock_t;

   // security level, one-hot as written
   typedef enum logic [3:0] {
      FSLC_LVL1 = 4'h1,
      FSLC_LVL2 = 4'h2,
      FSLC_LVL3 = 4'h4,
      FSLC_LVL4 = 4'h8
   } fslc_level_t;

   // flash operations judged
   typedef enum logic [2:0] {
      FSLC_OP_READ   = 3'h0,
      FSLC_OP_BERASE = 3'h1,
      FSLC_OP_SERASE = 3'h2,
      FSLC_OP_PROG   = 3'h3,
      FSLC_OP_VERIFY = 3'h4,
      FSLC_OP_CERASE = 3'h5
   } fslc_op_t;

   // one decode table entry: level plus lock of each block
   typedef struct packed {
      fslc_level_t level;
      fslc_lock_t  blk1;
      fslc_lock_t  blk0;
   } fslc_entry_t;
endpackage

// ---- rtl/fslc_table_if.sv ----
// carrier between the checker and its decode table memory
`timescale 1ns/1ps
interface fslc_table_if;
   import fslc_pkg::*;
   logic [2:0]  wr_idx;
   logic        wr_en;
   fslc_entry_t wr_data;
   logic [2:0]  rd_idx;
   fslc_entry_t rd_data;
   modport owner (output wr_idx, output wr_en, output wr_data, output rd_idx, input rd_data);
   modport mem   (input wr_idx, input wr_en, input wr_data, input rd_idx, output rd_data);
endinterface

// ---- rtl/fslc_table_mem.sv ----
// eight-entry lock decode table with registered read data
`timescale 1ns/1ps
module fslc_table_mem (
   input  wire logic    i_sys_clk,
   input  wire logic    i_rstn,
   fslc_table_if.mem    tbl
);
   import fslc_pkg::*;
   fslc_entry_t mem_reg [8];
   fslc_entry_t rd_reg;

   // default map: 0 open, 1 level two, 2..4 level three options, rest sealed
   function automatic fslc_entry_t fslc_dflt(input int idx);
      fslc_entry_t e;
      case (idx)
         0: e = '{FSLC_LVL1, FSLC_UNLOCKED, FSLC_UNLOCKED};
         1: e = '{FSLC_LVL2, FSLC_HARD, FSLC_HARD};
         2: e = '{FSLC_LVL3, FSLC_HARD, FSLC_SOFT};
         3: e = '{FSLC_LVL3, FSLC_SOFT, FSLC_SOFT};
         4: e = '{FSLC_LVL3, FSLC_HARD, FSLC_HARD};
         default: e = '{FSLC_LVL4, FSLC_HARD, FSLC_HARD};
      endcase
      return e;
   endfunction

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_ent
         always_ff @(posedge i_sys_clk) begin
            if (!i_rstn) begin
               mem_reg[g] <= fslc_dflt(g);
            end else if (tbl.wr_en && tbl.wr_idx == 3'(g)) begin
               mem_reg[g] <= tbl.wr_data;
            end
         end
      end
   endgenerate

   // registered read port
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         rd_reg <= fslc_dflt(0);
      end else begin
         rd_reg <= mem_reg[tbl.rd_idx];
      end
   end
   assign tbl.rd_data = rd_reg;
endmodule

// ---- verification/fslc_checker_properties.sv ----
// concurrent checks on the flash lock checker top ports
`timescale 1ns/1ps
`include "fslc_defines.svh"
module fslc_checker_properties
   import fslc_pkg::*;
(
   input wire logic                    i_sys_clk,
   input wire logic                    i_rstn,
   input wire logic [`FSLC_ADDR_W-1:0] i_reg_addr,
   input wire logic [7:0]              i_reg_wdata,
   input wire logic                    i_reg_wr,
   input wire logic                    i_reg_rd,
   input wire logic [7:0]              o_reg_rdata,
   input wire logic                    i_rd_req,
   input wire logic                    o_rd_valid,
   input wire logic [7:0]              o_rd_data,
   input wire logic                    o_rd_denied,
   input wire logic                    i_host_mode,
   input wire logic                    i_host_req,
   input wire fslc_op_t                i_host_op,
   input wire logic                    o_fl_go,
   input wire fslc_op_t                o_fl_op,
   input wire logic                    o_fl_verify_open,
   input wire logic                    o_cmd_denied,
   input wire logic                    o_ext_boot_block
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   // mailbox write beats a host command in the same cycle
   wire mbox_wr = i_reg_wr && (i_reg_addr == `FSLC_OFS_MAILBOX);
   sequence host_cmd;
      i_host_req && i_host_mode && !mbox_wr;
   endsequence
   sequence read_taken;
      i_rd_req ##1 (o_rd_valid ^ o_rd_denied);
   endsequence
   status_low_bits_a: assert property (i_reg_rd && i_reg_addr == `FSLC_OFS_STATUS |=> o_reg_rdata[4:0] == 5'h00)
      else $error("status low bits not zero");
   read_answer_a: assert property (i_rd_req |-> read_taken)
      else $error("code read got no single answer");
   denied_data_a: assert property (o_rd_denied |-> o_rd_data == 8'h00 && !o_rd_valid)
      else $error("refused read returned data");
   read_quiet_a: assert property (!i_rd_req |=> !o_rd_valid && !o_rd_denied)
      else $error("read answer without request");
   go_or_deny_a: assert property (o_fl_go |-> !o_cmd_denied)
      else $error("command both passed and refused");
   host_erase_a: assert property (host_cmd ##0 (i_host_op == FSLC_OP_CERASE) |=> o_fl_go && o_fl_op == FSLC_OP_CERASE)
      else $error("host chip erase not passed");
   verify_open_a: assert property (o_fl_verify_open |-> o_fl_go && o_fl_op == FSLC_OP_VERIFY)
      else $error("verify open without verify");
   top_level_read_a: assert property (i_rd_req ##1 o_ext_boot_block |-> o_rd_denied)
      else $error("read passed at top level");
   top_level_host_a: assert property (host_cmd ##0 (i_host_op != FSLC_OP_CERASE) ##1 o_ext_boot_block
      |-> o_cmd_denied)
      else $error("host command passed at top level");
endmodule
bind fslc_checker fslc_checker_properties chk_i (.i_sys_clk, .i_rstn, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
   .i_reg_rd, .o_reg_rdata, .i_rd_req, .o_rd_valid, .o_rd_data, .o_rd_denied, .i_host_mode, .i_host_req,
   .i_host_op, .o_fl_go, .o_fl_op, .o_fl_verify_open, .o_cmd_denied, .o_ext_boot_block);

// ---- verification/fslc_flash_model.sv ----
// flash array model: raw byte per block while a code read is asked
`timescale 1ns/1ps
module fslc_flash_model (
   input  wire logic       i_sys_clk,
   input  wire logic       i_rd_req,
   input  wire logic       i_rd_blk,
   output logic [7:0]      o_rd_flash_data
);
   logic [7:0] noise_reg = 8'h00;
   // off-request bus changes every cycle so stale data cannot pass unseen
   always @(posedge i_sys_clk) noise_reg <= noise_reg + 8'h3B;
   assign o_rd_flash_data = i_rd_req ? (i_rd_blk ? 8'h3C : 8'hA5) : noise_reg;
endmodule

// ---- verification/flash_security_lock_checker_tb.sv ----
// self-checking bench for the flash lock checker
`timescale 1ns/1ps
module flash_security_lock_checker_tb;
   import fslc_pkg::*;
   logic i_sys_clk = 0, i_rstn = 0, i_reg_wr = 0, i_reg_rd = 0, i_rd_req = 0, i_rd_blk = 0;
   logic i_rd_src_ext = 0, i_rd_src_blk = 0, i_host_mode = 0, i_host_req = 0, i_host_blk = 0;
   logic i_ext_access_n = 1;
   logic [3:0] i_reg_addr = 4'h0;
   logic [7:0] i_reg_wdata = 8'h00, o_reg_rdata, o_rd_data, fdata;
   fslc_op_t i_host_op = FSLC_OP_READ, o_fl_op;
   logic o_rd_valid, o_rd_denied, o_fl_go, o_fl_blk, o_fl_verify_open, o_cmd_denied, o_ext_boot_block;
   int failures = 0, comparisons = 0;
   always #4 i_sys_clk = ~i_sys_clk;
   fslc_flash_model flash (.i_sys_clk(i_sys_clk), .i_rd_req(i_rd_req), .i_rd_blk(i_rd_blk), .o_rd_flash_data(fdata));
   fslc_checker dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_rd_req(i_rd_req),
      .i_rd_blk(i_rd_blk), .i_rd_src_ext(i_rd_src_ext), .i_rd_src_blk(i_rd_src_blk), .i_rd_flash_data(fdata),
      .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_rd_denied(o_rd_denied), .i_host_mode(i_host_mode),
      .i_host_req(i_host_req), .i_host_op(i_host_op), .i_host_blk(i_host_blk), .i_ext_access_n(i_ext_access_n),
      .o_fl_go(o_fl_go), .o_fl_op(o_fl_op), .o_fl_blk(o_fl_blk), .o_fl_verify_open(o_fl_verify_open),
      .o_cmd_denied(o_cmd_denied), .o_ext_boot_block(o_ext_boot_block));
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_sys_clk) begin i_reg_wr <= 1; i_reg_addr <= a; i_reg_wdata <= d; end
      @(posedge i_sys_clk) i_reg_wr <= 0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge i_sys_clk) begin i_reg_rd <= 1; i_reg_addr <= a; end
      @(posedge i_sys_clk) i_reg_rd <= 0;
      @(negedge i_sys_clk) chk(o_reg_rdata, e);
   endtask
   // reset then program lock bits; lookup trails the bits by one cycle
   task automatic rst(input logic [2:0] lk);
      @(posedge i_sys_clk) i_rstn <= 0;
      repeat (8) @(posedge i_sys_clk);
      i_rstn <= 1;
      repeat (2) @(posedge i_sys_clk);
      wr(4'h2, {5'h00, lk});
      repeat (2) @(posedge i_sys_clk);
   endtask
   task automatic cread(input logic b, x, sb, ok);
      @(posedge i_sys_clk) begin i_rd_req <= 1; i_rd_blk <= b; i_rd_src_ext <= x; i_rd_src_blk <= sb; end
      @(posedge i_sys_clk) i_rd_req <= 0;
      @(negedge i_sys_clk) chk({o_rd_valid, o_rd_denied}, {6'h00, ok, !ok});
      chk(o_rd_data, ok ? (b ? 8'h3C : 8'hA5) : 8'h00);
   endtask
   task automatic host(input fslc_op_t op, input logic b, ok);
      @(posedge i_sys_clk) begin i_host_req <= 1; i_host_op <= op; i_host_blk <= b; end
      @(posedge i_sys_clk) i_host_req <= 0;
      @(negedge i_sys_clk) chk({1'b0, o_fl_verify_open, o_fl_op, o_fl_go, o_cmd_denied, o_fl_blk},
                               {1'b0, (ok && op == FSLC_OP_VERIFY), op, ok, !ok, b});
   endtask
   task automatic mbox(input fslc_op_t op, input logic ok);
      wr(4'h3, {5'h00, op});
      @(negedge i_sys_clk) chk({1'b0, o_fl_verify_open, o_fl_op, o_fl_blk, o_fl_go, o_cmd_denied},
                               {1'b0, (ok && op == FSLC_OP_VERIFY), op, 1'b0, ok, !ok});
   endtask
   initial begin
      #200000;
      failures++;
      end_sim();
   end
   initial begin
      rst(3'h0);
      i_host_mode <= 1;
      rd(4'h0, 8'h00);
      rd(4'h1, 8'h00);
      rd(4'h6, 8'h00);
      cread(1, 1, 0, 1);
      host(FSLC_OP_PROG, 0, 1);
      $display("test open level done");
      rst(3'h4);
      rd(4'h0, 8'h80);
      cread(1, 1, 0, 0);
      host(FSLC_OP_PROG, 1, 0);
      host(FSLC_OP_CERASE, 1, 1);
      chk({7'h00, o_ext_boot_block}, 8'h00);
      $display("test both hard done");
      rst(3'h1);
      host(FSLC_OP_VERIFY, 0, 1);
      host(FSLC_OP_PROG, 0, 0);
      wr(4'h9, 8'h10);
      host(FSLC_OP_PROG, 0, 1);
      $display("test level two done");
      rst(3'h2);
      cread(1, 1, 0, 0);
      cread(0, 1, 0, 1);
      host(FSLC_OP_PROG, 0, 0);
      $display("test secondary hard done");
      rst(3'h3);
      host(FSLC_OP_VERIFY, 0, 0);
      wr(4'h1, 8'h40);
      wr(4'h4, 8'h00);
      i_rd_src_ext <= 0;
      i_rd_src_blk <= 1;
      mbox(FSLC_OP_PROG, 1);
      mbox(FSLC_OP_SERASE, 1);
      rd(4'h5, 8'h01);
      mbox(FSLC_OP_VERIFY, 1);
      wr(4'h1, 8'h00);
      mbox(FSLC_OP_BERASE, 0);
      rd(4'h5, 8'h02);
      wr(4'h1, 8'h40);
      i_ext_access_n <= 0;
      repeat (3) @(posedge i_sys_clk);
      mbox(FSLC_OP_CERASE, 1);
      repeat (2) @(posedge i_sys_clk);
      rd(4'h0, 8'h00);
      $display("test soft mailbox done");
      rst(3'h7);
      @(negedge i_sys_clk) chk({7'h00, o_ext_boot_block}, 8'h01);
      cread(0, 1, 0, 0);
      host(FSLC_OP_VERIFY, 0, 0);
      wr(4'h1, 8'h40);
      mbox(FSLC_OP_CERASE, 0);
      $display("test top level done");
      end_sim();
   end
endmodule
